// >>> shared/sys_seq_pkg.sv
package sys_seq_pkg;
  // ----------------------------------------------------------------
  // register map (word aligned byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_BREAK_EXIT  = 8'h00;
  localparam logic [7:0] ADDR_RESET_CAUSE = 8'h04;
  localparam logic [7:0] ADDR_BREAK_CLR   = 8'h08;
  localparam logic [7:0] ADDR_CONTROL     = 8'h0C;
  localparam logic [7:0] ADDR_STATE       = 8'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_BREAK_EXIT_WAIT = 1;
  localparam int BIT_CLR_ENABLE      = 7;
  localparam int BIT_WDOG_DISABLE    = 0;
  localparam int BIT_STOP_ALLOW      = 1;
  localparam int CAUSE_FORCED_MON    = 1;
  localparam int CAUSE_LOW_VOLT      = 1;
  // reset cause bit positions
  localparam int RC_LVI  = 1;
  localparam int RC_MON  = 2;
  localparam int RC_ILLEGAL_ADDRESS_FLAG = 3;
  localparam int RC_ILLEGAL_OPCODE_FLAG = 4;
  localparam int RC_WDOG = 5;
  localparam int RC_PIN  = 6;
  localparam int RC_POR  = 7;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0]  RESET_CAUSE_POR   = 8'h80;
  localparam logic [7:0]  BREAK_CLR_RESET   = 8'h00;
  localparam logic [7:0]  CONTROL_RESET     = 8'h00;
  localparam int          PRESCALE_WIDTH    = 13;
  localparam logic [12:0] LONG_HOLD_CYCLES  = 13'h1000;
  localparam logic [12:0] TAIL_CYCLES       = 13'h0040;
  localparam logic [12:0] PIN_DRIVE_CYCLES  = 13'h0020;
  localparam logic [12:0] INTERNAL_RESET_SIGNAL_EXTRA_CYCLES = 13'h0020;
  localparam logic [12:0] STOP_RECOVERY     = 13'h1000;
  localparam int          NUM_IRQ           = 8;
  localparam logic [7:0]  ERASED_VECTOR     = 8'hFF;

  typedef enum logic [4:0] {
    ST_RUN    = 5'h01,
    ST_RESET  = 5'h02,
    ST_WAIT   = 5'h04,
    ST_STOP   = 5'h08,
    ST_RECOV  = 5'h10
  } seq_state_t;
endpackage

// >>> core/system_reset_exception_sequencer.sv
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Contract
// - illegal opcode sets flag and resets
// - stop instruction acts as illegal opcode; enters stop if stop allow bit set
// - bad opcode fetch address resets; data fetch not
// - erased reset vectors force monitor reset
// - low voltage: pin low 4096, release 64 later
// - 13-bit prescaler on oscillator falling edge
// - prescaler overflow clocks the watchdog
// - pin reset keeps prescaler; runs freely after
// - latched interrupt cannot be preempted
// - arbitration result given as constant vector code
// - take interrupt at boundary if unmasked, enabled
// - highest priority first; pending taken after return
// - software interrupt ignores mask
// - resets share top priority, no arbitration
// - wait stops cpu clock, clears mask
// - enabled interrupt wakes wait, stacking next cycle
// - reset exits wait; watchdog runs unless disabled
// - stop resets prescaler; exit after 4096 cycles
// - break exit wait bit, cleared by zero write
// - reading reset cause clears all flags
// - power-on sets only its own flag
// - in break, clears need clear enable bit
// - internal reset drives pin 32, then 32 more
module system_reset_exception_sequencer (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        osc_clk,
  input  wire logic        por_pulse,
  input  wire logic        pin_reset_n,
  input  wire logic        low_voltage,
  input  wire logic        wdog_timeout,
  input  wire logic        illegal_op,
  input  wire logic        stop_op,
  input  wire logic        wait_op,
  input  wire logic        swi_op,
  input  wire logic        opcode_fetch,
  input  wire logic        addr_unmapped,
  input  wire logic        vector_fetch,
  input  wire logic [7:0]  vector_data,
  input  wire logic        insn_done,
  input  wire logic        cpu_mask,
  input  wire logic        irq_serviced,
  input  wire logic [7:0]  irq_req,
  input  wire logic [7:0]  irq_en,
  input  wire logic        break_req,
  input  wire logic        break_state,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             rst_pin_out,
  output logic             rst_pin_oe,
  output logic             internal_reset,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             osc_enable,
  output logic             monitor_mode,
  output logic             irq_take,
  output logic [2:0]       irq_vector,
  output logic             clear_mask,
  output logic             wdog_tick,
  output logic             wdog_enable
);

  // ----------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------
  sys_seq_pkg::seq_state_t state_q;
  logic [7:0]  cause_q;
  logic        brk_exit_q;
  logic [7:0]  brk_ctl_q;
  logic [7:0]  ctl_q;
  logic [12:0] seq_cnt_q;
  logic        long_hold_q;
  logic        mon_q;
  logic        irq_lat_q;
  logic [2:0]  irq_vec_q;
  logic        osc_q;
  logic [12:0] presc_q;
  logic        wr_pend_q;
  logic        rd_pend_q;
  logic [7:0]  wr_addr_q;
  logic        ovf_q;

  function automatic logic [2:0] prio_enc(input logic [7:0] v);
    prio_enc = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        prio_enc = i[2:0];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------
  logic illegal_opcode_flag_ev;
  logic illegal_address_flag_ev;
  logic mon_ev;
  logic pin_ev;
  logic int_rst_ev;
  logic any_rst_ev;
  logic stop_req;
  logic [7:0] pend;
  logic can_clear;
  logic osc_fall;

  assign stop_req   = stop_op & ctl_q[sys_seq_pkg::BIT_STOP_ALLOW];
  assign illegal_opcode_flag_ev    = illegal_op | (stop_op & ~ctl_q[sys_seq_pkg::BIT_STOP_ALLOW]);
  assign illegal_address_flag_ev    = opcode_fetch & addr_unmapped;
  assign mon_ev     = vector_fetch & (vector_data == sys_seq_pkg::ERASED_VECTOR);
  assign pin_ev     = ~pin_reset_n;
  // all sources merged without ranking
  assign int_rst_ev = illegal_opcode_flag_ev | illegal_address_flag_ev | mon_ev | wdog_timeout | low_voltage;
  assign any_rst_ev = int_rst_ev | pin_ev | por_pulse;
  assign pend       = irq_req & irq_en;
  assign can_clear  = ~break_state | brk_ctl_q[sys_seq_pkg::BIT_CLR_ENABLE];
  assign osc_fall   = osc_q & ~osc_clk;

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  logic addr_ok;
  logic rd_cause;
  assign addr_ok   = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign rd_cause  = addr_ok & ~hwrite & (haddr == sys_seq_pkg::ADDR_RESET_CAUSE);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok & hwrite;
      rd_pend_q <= addr_ok & ~hwrite;
      wr_addr_q <= haddr;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok & ~hwrite) begin
      case (haddr)
        sys_seq_pkg::ADDR_BREAK_EXIT:
          hrdata <= {30'h0, brk_exit_q, 1'b0};
        sys_seq_pkg::ADDR_RESET_CAUSE:  hrdata <= {24'h0, cause_q};
        sys_seq_pkg::ADDR_BREAK_CLR:    hrdata <= {24'h0, brk_ctl_q};
        sys_seq_pkg::ADDR_CONTROL:      hrdata <= {24'h0, ctl_q};
        sys_seq_pkg::ADDR_STATE:        hrdata <= {19'h0, presc_q};
        default:                        hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      brk_ctl_q <= sys_seq_pkg::BREAK_CLR_RESET;
      ctl_q     <= sys_seq_pkg::CONTROL_RESET;
    end else if (wr_pend_q) begin
      if (wr_addr_q == sys_seq_pkg::ADDR_BREAK_CLR) begin
        brk_ctl_q <= {hwdata[7], 7'h00};
      end
      if (wr_addr_q == sys_seq_pkg::ADDR_CONTROL) begin
        ctl_q <= {6'h00, hwdata[1:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // reset cause flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cause_q <= sys_seq_pkg::RESET_CAUSE_POR;
    end else if (por_pulse) begin
      cause_q <= sys_seq_pkg::RESET_CAUSE_POR;
    end else if (any_rst_ev && state_q != sys_seq_pkg::ST_RESET) begin
      cause_q <= {1'b0, pin_ev, wdog_timeout, illegal_opcode_flag_ev, illegal_address_flag_ev, mon_ev, low_voltage, 1'b0};
    end else if (rd_cause & can_clear) begin
      cause_q <= 8'h00;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      brk_exit_q <= 1'b0;
    end else if (state_q == sys_seq_pkg::ST_WAIT && break_req) begin
      brk_exit_q <= 1'b1;
    end else if (wr_pend_q && wr_addr_q == sys_seq_pkg::ADDR_BREAK_EXIT
                 && !hwdata[sys_seq_pkg::BIT_BREAK_EXIT_WAIT] && can_clear) begin
      brk_exit_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // prescaler on oscillator falling edge
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      osc_q   <= 1'b0;
      presc_q <= 13'h0000;
      ovf_q   <= 1'b0;
    end else begin
      osc_q <= osc_clk;
      ovf_q <= 1'b0;
      if (state_q == sys_seq_pkg::ST_STOP) begin
        presc_q <= 13'h0000;
      end else if (int_rst_ev | por_pulse) begin
        presc_q <= 13'h0000;
      end else if (osc_fall) begin
        presc_q <= presc_q + 13'h0001;
        ovf_q   <= &presc_q;
      end
    end
  end
  assign wdog_tick   = ovf_q;
  assign wdog_enable = ~ctl_q[sys_seq_pkg::BIT_WDOG_DISABLE];

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q     <= sys_seq_pkg::ST_RESET;
      seq_cnt_q   <= 13'h0000;
      long_hold_q <= 1'b1;
      mon_q       <= 1'b0;
    end else begin
      case (state_q)
        sys_seq_pkg::ST_RESET: begin
          if (pin_ev) begin
            seq_cnt_q <= 13'h0000;
          end else if (osc_fall) begin
            seq_cnt_q <= seq_cnt_q + 13'h0001;
          end
          if (long_hold_q && osc_fall
              && seq_cnt_q == sys_seq_pkg::LONG_HOLD_CYCLES + sys_seq_pkg::TAIL_CYCLES - 13'h0001)
          begin
            state_q <= sys_seq_pkg::ST_RUN;
          end
          if (!long_hold_q && osc_fall && seq_cnt_q ==
              sys_seq_pkg::PIN_DRIVE_CYCLES + sys_seq_pkg::INTERNAL_RESET_SIGNAL_EXTRA_CYCLES - 13'h0001) begin
            state_q <= sys_seq_pkg::ST_RUN;
          end
        end
        sys_seq_pkg::ST_RUN: begin
          if (wait_op) begin
            state_q <= sys_seq_pkg::ST_WAIT;
          end else if (stop_req) begin
            state_q <= sys_seq_pkg::ST_STOP;
          end
        end
        sys_seq_pkg::ST_WAIT: begin
          if (|pend || break_req) begin
            state_q <= sys_seq_pkg::ST_RUN;
          end
        end
        sys_seq_pkg::ST_STOP: begin
          seq_cnt_q <= 13'h0000;
          if (|pend || break_req) begin
            state_q <= sys_seq_pkg::ST_RECOV;
          end
        end
        sys_seq_pkg::ST_RECOV: begin
          if (osc_fall) begin
            seq_cnt_q <= seq_cnt_q + 13'h0001;
          end
          if (osc_fall && seq_cnt_q == sys_seq_pkg::STOP_RECOVERY - 13'h0001) begin
            state_q <= sys_seq_pkg::ST_RUN;
          end
        end
        default: state_q <= sys_seq_pkg::ST_RESET;
      endcase
      if (any_rst_ev) begin
        state_q     <= sys_seq_pkg::ST_RESET;
        seq_cnt_q   <= 13'h0000;
        long_hold_q <= low_voltage | por_pulse;
      end
      if (mon_ev) begin
        mon_q <= 1'b1;
      end else if (por_pulse) begin
        mon_q <= 1'b0;
      end
    end
  end

  logic in_rst;
  assign in_rst         = (state_q == sys_seq_pkg::ST_RESET);
  assign internal_reset = in_rst;
  assign rst_pin_out    = 1'b0;
  assign rst_pin_oe     = in_rst && (long_hold_q ? seq_cnt_q < sys_seq_pkg::LONG_HOLD_CYCLES
                                     : seq_cnt_q < sys_seq_pkg::PIN_DRIVE_CYCLES);
  assign cpu_clk_en     = (state_q == sys_seq_pkg::ST_RUN);
  assign periph_clk_en  = (state_q != sys_seq_pkg::ST_STOP) && (state_q != sys_seq_pkg::ST_RECOV);
  assign osc_enable     = (state_q != sys_seq_pkg::ST_STOP);
  assign monitor_mode   = mon_q & ~in_rst;
  assign clear_mask     = (state_q == sys_seq_pkg::ST_RUN) & wait_op;

  // ----------------------------------------------------------------
  // interrupt latch and arbitration
  // ----------------------------------------------------------------
  logic boundary;
  assign boundary = insn_done | (state_q == sys_seq_pkg::ST_WAIT);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_lat_q <= 1'b0;
      irq_vec_q <= 3'h0;
      irq_take  <= 1'b0;
    end else begin
      irq_take <= 1'b0;
      if (in_rst) begin
        irq_lat_q <= 1'b0;
      end else if (irq_lat_q) begin
        if (irq_serviced || cpu_mask) begin
          irq_lat_q <= 1'b0;
        end
      end else if (boundary && swi_op) begin
        irq_take  <= 1'b1;
        irq_vec_q <= 3'h0;
      end else if (boundary && !cpu_mask && |pend) begin
        irq_lat_q <= 1'b1;
        irq_take  <= 1'b1;
        irq_vec_q <= prio_enc(pend);
      end
    end
  end
  assign irq_vector = irq_vec_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_illegal_opcode_flag_resets: assert property (@(posedge clk_sys) disable iff (rst)
    illegal_op |=> in_rst) else $error("illegal opcode did not reset");
  a_stop_illegal_opcode_flag: assert property (@(posedge clk_sys) disable iff (rst)
    stop_op && !ctl_q[sys_seq_pkg::BIT_STOP_ALLOW] |=> in_rst && cause_q[sys_seq_pkg::RC_ILLEGAL_OPCODE_FLAG])
    else $error("stop not illegal");
  a_illegal_address_flag_flag: assert property (@(posedge clk_sys) disable iff (rst)
    illegal_address_flag_ev && !por_pulse && !in_rst |=> cause_q[3]) else $error("illegal_address_flag flag missing");
  a_mon_flag: assert property (@(posedge clk_sys) disable iff (rst)
    mon_ev |=> mon_q && in_rst) else $error("monitor entry missing");
  a_latch_hold: assert property (@(posedge clk_sys) disable iff (rst)
    irq_lat_q && !irq_serviced && !cpu_mask && !in_rst |=> $stable(irq_vec_q))
    else $error("latched interrupt preempted");
  a_mask_block: assert property (@(posedge clk_sys) disable iff (rst)
    cpu_mask && !swi_op |=> !irq_take) else $error("masked interrupt taken");
  a_wait_wake: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == sys_seq_pkg::ST_WAIT && |pend && !any_rst_ev |=> cpu_clk_en)
    else $error("wait not exited");
  a_stop_presc: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == sys_seq_pkg::ST_STOP |=> presc_q == 13'h0000) else $error("prescaler not reset");
  a_por_cause: assert property (@(posedge clk_sys) disable iff (rst)
    por_pulse |=> cause_q == 8'h80) else $error("por cause wrong");
  c_wait_exit: cover property (@(posedge clk_sys) state_q == sys_seq_pkg::ST_WAIT ##1 cpu_clk_en);
  c_irq_taken: cover property (@(posedge clk_sys) irq_take && irq_vec_q != 3'h0);
  c_reset_run: cover property (@(posedge clk_sys) in_rst ##1 !in_rst);

endmodule

// >>> tb/cpu_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// core and oscillator model
// ----------------------------------------
module cpu_model (
  input  wire logic       clk_sys,
  input  wire logic       cpu_clk_en,
  input  wire logic       internal_reset,
  output logic            osc_clk,
  output logic            insn_done,
  output logic            illegal_op,
  output logic            stop_op,
  output logic            wait_op,
  output logic            swi_op,
  output logic            opcode_fetch,
  output logic            addr_unmapped,
  output logic            vector_fetch,
  output logic [7:0]      vector_data
);
  initial begin
    {osc_clk, insn_done, illegal_op, stop_op, wait_op, swi_op} = 6'h00;
    {opcode_fetch, addr_unmapped, vector_fetch} = 3'h0;
    vector_data = 8'h00;
  end
  // free running: osc_enable is ignored, so the oscillator keeps toggling in stop mode
  always @(posedge clk_sys) osc_clk <= ~osc_clk;
  // op 0 plain, 1 illegal, 2 stop, 3 wait, 4 swi, 5 bad fetch, 6 data fetch
  task automatic insn(input logic [2:0] op);
    int n;
    n = 0;
    // a stopped or held core issues nothing
    while (!(cpu_clk_en === 1'b1 && internal_reset === 1'b0) && n < 20000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 20000) testbench.fails++;
    insn_done     <= (op == 3'h0) || (op == 3'h3) || (op == 3'h4);
    illegal_op    <= (op == 3'h1);
    stop_op       <= (op == 3'h2);
    wait_op       <= (op == 3'h3);
    swi_op        <= (op == 3'h4);
    opcode_fetch  <= (op == 3'h5);
    addr_unmapped <= (op == 3'h5) || (op == 3'h6);
    @(posedge clk_sys);
    {insn_done, illegal_op, stop_op, wait_op, swi_op} <= 5'h00;
    {opcode_fetch, addr_unmapped} <= 2'h0;
  endtask
  task automatic vec(input logic [7:0] dv);
    vector_fetch <= 1'b1;
    vector_data  <= dv;
    @(posedge clk_sys);
    vector_fetch <= 1'b0;
    // released bus never keeps the fetched value
    vector_data  <= ~dv;
  endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        clk_sys, rst, por_pulse, pin_reset_n, low_voltage, wdog_timeout;
  logic        cpu_mask, irq_serviced, break_req, break_state, hsel, hwrite, hready;
  logic        hreadyout, hresp, rst_pin_out, rst_pin_oe, internal_reset, cpu_clk_en;
  logic        periph_clk_en, osc_enable, monitor_mode, irq_take, clear_mask;
  logic        wdog_tick, wdog_enable, osc_clk, insn_done, illegal_op, stop_op;
  logic        wait_op, swi_op, opcode_fetch, addr_unmapped, vector_fetch, osc_q, g;
  logic [7:0]  vector_data, irq_req, irq_en, haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize, irq_vector, v;
  logic [31:0] hwdata, hrdata, d, p0;
  int          fails = 0, num_checks = 0, oe_falls = 0, internal_reset_signal_falls = 0;
  int          pfalls = 0, cm_cnt = 0, pf, dif, cm0, po;
  logic [7:0]  iq [7] = '{8'h80, 8'h0C, 8'h08, 8'h03, 8'h10, 8'h01, 8'h00};
  logic [7:0]  ie [7] = '{8'hFF, 8'hFF, 8'hFF, 8'h02, 8'h0F, 8'hFF, 8'hFF};
  logic [2:0]  iv [7] = '{3'h7, 3'h2, 3'h3, 3'h1, 3'h0, 3'h0, 3'h0};
  logic [2:0]  ts [7] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h1, 3'h4};
  logic [2:0]  to [7] = '{3'h1, 3'h2, 3'h5, 3'h7, 3'h7, 3'h1, 3'h7};
  logic [7:0]  tc [7] = '{8'h10, 8'h10, 8'h08, 8'h20, 8'h02, 8'h30, 8'h04};
  logic [6:0]  im = 7'h60;
  logic [6:0]  ig = 7'h4F;

  assign hready = hreadyout;
  initial clk_sys = 1'b0;
  always #20 clk_sys = ~clk_sys;

  system_reset_exception_sequencer system_reset_exception_sequencer_inst (
    .clk_sys, .rst, .osc_clk, .por_pulse, .pin_reset_n, .low_voltage, .wdog_timeout,
    .illegal_op, .stop_op, .wait_op, .swi_op, .opcode_fetch, .addr_unmapped,
    .vector_fetch, .vector_data, .insn_done, .cpu_mask, .irq_serviced, .irq_req,
    .irq_en, .break_req, .break_state, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .rst_pin_out, .rst_pin_oe,
    .internal_reset, .cpu_clk_en, .periph_clk_en, .osc_enable, .monitor_mode,
    .irq_take, .irq_vector, .clear_mask, .wdog_tick, .wdog_enable);
  cpu_model cpu_model_inst (.clk_sys, .cpu_clk_en, .internal_reset, .osc_clk,
    .insn_done, .illegal_op, .stop_op, .wait_op, .swi_op, .opcode_fetch,
    .addr_unmapped, .vector_fetch, .vector_data);

  // ----------------------------------------
  // oscillator fall counters
  // ----------------------------------------
  always @(posedge clk_sys) begin
    osc_q <= osc_clk;
    if (clear_mask === 1'b1) cm_cnt++;
    if (rst === 1'b0 && osc_q === 1'b1 && osc_clk === 1'b0) begin
      pfalls++;
      if (rst_pin_oe === 1'b1) oe_falls++;
      if (internal_reset === 1'b1) internal_reset_signal_falls++;
    end
  end

  // ----------------------------------------
  // checks and bus tasks
  // ----------------------------------------
  task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // counts are sampled a few edges late, so allow a small slack
  task automatic chk_rng(input string n, input int e, input int s);
    num_checks++;
    if (s < e - 3 || s > e + 3) begin
      fails++;
      $display("[ERR] %s expected %0d seen %0d", n, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic ready_edge;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      tally_and_finish;
    end
  endtask
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    hsize  <= 3'h2;
    htrans <= 2'h2;
    ready_edge;
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= w ? wd : hwdata;
    ready_edge;
    d = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string n);
    ahb(a, 1'b0, 32'h0);
    chk_val(n, e, d);
  endtask
  task automatic wait_run;
    int n;
    n = 0;
    repeat (4) @(posedge clk_sys);
    while ((internal_reset !== 1'b0 || rst_pin_oe !== 1'b0) && n < 20000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 20000) begin
      fails++;
      tally_and_finish;
    end
  endtask
  task automatic wait_take;
    g = 1'b0;
    v = 3'h0;
    repeat (30) begin
      @(posedge clk_sys);
      if (irq_take === 1'b1 && !g) begin
        g = 1'b1;
        v = irq_vector;
      end
    end
  endtask
  task automatic service;
    irq_serviced <= g;
    @(posedge clk_sys);
    irq_serviced <= 1'b0;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {por_pulse, low_voltage, wdog_timeout, cpu_mask, irq_serviced} = 5'h00;
    {break_req, break_state, hsel, hwrite, rst} = 5'h01;
    {irq_req, irq_en, haddr, hwdata} = 56'h0;
    pin_reset_n = 1'b1;
    htrans = 2'h0;
    hsize = 3'h2;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    wait_run;
    chk_rng("power up pin hold", 4096, oe_falls);
    chk_rng("power up release", 4160, internal_reset_signal_falls);
    chk_val("pin and bus", 32'h2, {29'h0, rst_pin_out, hreadyout, hresp});
    rd_chk(sys_seq_pkg::ADDR_RESET_CAUSE, 32'h80, "cause power up");
    rd_chk(sys_seq_pkg::ADDR_RESET_CAUSE, 32'h00, "cause after read");
    rd_chk(sys_seq_pkg::ADDR_BREAK_CLR, 32'h00, "clear ctrl reset");
    rd_chk(sys_seq_pkg::ADDR_BREAK_EXIT, 32'h00, "break exit reset");
    ahb(8'h14, 1'b1, 32'hFF);
    rd_chk(8'h14, 32'h00, "unmapped");
    cpu_model_inst.insn(3'h6);
    repeat (8) @(posedge clk_sys);
    chk_val("data fetch reset", 32'h0, {31'h0, internal_reset});
    // external pin reset keeps the prescaler running
    ahb(sys_seq_pkg::ADDR_STATE, 1'b0, 32'h0);
    p0 = d;
    pf = pfalls;
    pin_reset_n <= 1'b0;
    repeat (200) @(posedge clk_sys);
    pin_reset_n <= 1'b1;
    wait_run;
    ahb(sys_seq_pkg::ADDR_STATE, 1'b0, 32'h0);
    dif = ((int'(d[12:0]) - int'(p0[12:0]) - (pfalls - pf)) % 8192 + 8192) % 8192;
    if (dif > 4096) dif -= 8192;
    chk_rng("prescaler over pin reset", 0, dif);
    break_state <= 1'b1;
    rd_chk(sys_seq_pkg::ADDR_RESET_CAUSE, 32'h40, "cause pin");
    rd_chk(sys_seq_pkg::ADDR_RESET_CAUSE, 32'h40, "cause kept in break");
    ahb(sys_seq_pkg::ADDR_BREAK_CLR, 1'b1, 32'h80);
    rd_chk(sys_seq_pkg::ADDR_BREAK_CLR, 32'h80, "clear enable");
    rd_chk(sys_seq_pkg::ADDR_RESET_CAUSE, 32'h40, "cause read in break");
    rd_chk(sys_seq_pkg::ADDR_RESET_CAUSE, 32'h00, "cause cleared in break");
    break_state <= 1'b0;
    ahb(sys_seq_pkg::ADDR_BREAK_CLR, 1'b1, 32'h00);
    // arbitration, masking, enables, software interrupt
    for (int i = 0; i < 7; i++) begin
      irq_req  <= iq[i];
      irq_en   <= ie[i];
      cpu_mask <= im[i];
      cpu_model_inst.insn(i == 6 ? 3'h4 : 3'h0);
      wait_take;
      chk_val("irq taken", {31'h0, ig[i]}, {31'h0, g});
      chk_val("irq vector", {29'h0, iv[i]}, {29'h0, v});
      irq_req <= iq[i] & ~(8'h01 << v);
      service;
    end
    irq_req <= 8'h00;
    cpu_mask <= 1'b1;
    cm0 = cm_cnt;
    cpu_model_inst.insn(3'h3);
    repeat (4) @(posedge clk_sys);
    chk_val("clocks in wait", 32'h1, {30'h0, cpu_clk_en, periph_clk_en});
    chk_val("mask clear pulse", 32'h1, 32'(cm_cnt - cm0));
    chk_val("watchdog in wait", 32'h1, {31'h0, wdog_enable});
    irq_req  <= 8'h20;
    cpu_mask <= 1'b0;
    wait_take;
    chk_val("wake vector", 32'hD, {28'h0, g, v});
    chk_val("core clock after wake", 32'h1, {31'h0, cpu_clk_en});
    irq_req <= 8'h00;
    service;
    cpu_model_inst.insn(3'h3);
    repeat (4) @(posedge clk_sys);
    break_req <= 1'b1;
    @(posedge clk_sys);
    break_req <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rd_chk(sys_seq_pkg::ADDR_BREAK_EXIT, 32'h02, "break ended wait");
    ahb(sys_seq_pkg::ADDR_BREAK_EXIT, 1'b1, 32'h00);
    rd_chk(sys_seq_pkg::ADDR_BREAK_EXIT, 32'h00, "break exit cleared");
    // stop allowed only while the control bit is set
    ahb(sys_seq_pkg::ADDR_CONTROL, 1'b1, 32'h02);
    cpu_model_inst.insn(3'h2);
    repeat (4) @(posedge clk_sys);
    rd_chk(sys_seq_pkg::ADDR_STATE, 32'h0, "prescaler in stop");
    chk_val("clocks in stop", 32'h0, {30'h0, osc_enable, periph_clk_en});
    irq_req <= 8'h01;
    pf = pfalls;
    for (int n = 0; n < 9000 && cpu_clk_en !== 1'b1; n++) @(posedge clk_sys);
    chk_rng("stop recovery", 4096, pfalls - pf);
    irq_req <= 8'h00;
    ahb(sys_seq_pkg::ADDR_CONTROL, 1'b1, 32'h00);
    // internal reset sources; erased vectors last since monitor mode sticks
    for (int i = 0; i < 7; i++) begin
      po = ts[i][1] ? 4096 : 32;
      oe_falls = 0;
      internal_reset_signal_falls = 0;
      wdog_timeout <= ts[i][0];
      low_voltage  <= ts[i][1];
      if (ts[i][2]) cpu_model_inst.vec(8'hFF);
      else cpu_model_inst.insn(to[i]);
      wdog_timeout <= 1'b0;
      low_voltage  <= 1'b0;
      wait_run;
      chk_rng("pin drive", po, oe_falls);
      chk_rng("reset release", po + (ts[i][1] ? 64 : 32), internal_reset_signal_falls);
      rd_chk(sys_seq_pkg::ADDR_RESET_CAUSE, {24'h0, tc[i]}, "cause");
    end
    chk_val("monitor entry", 32'h1, {31'h0, monitor_mode});
    cpu_model_inst.vec(8'h5A);
    repeat (8) @(posedge clk_sys);
    chk_val("good vector no reset", 32'h0, {31'h0, internal_reset});
    for (int n = 0; n < 17500 && wdog_tick !== 1'b1; n++) @(posedge clk_sys);
    chk_val("watchdog tick", 32'h1, {31'h0, wdog_tick});
    tally_and_finish;
  end
endmodule
